//--- shared/cycle_log_defs.vh
`ifndef CYCLE_LOG_DEFS_VH
`define CYCLE_LOG_DEFS_VH

// timing
`define CLK_PERIOD_NS 32'h00000032
`define TICK_PERIOD_MS 32'h000003E8
`define TICK_CYCLES ((`TICK_PERIOD_MS * 32'h000F4240) / `CLK_PERIOD_NS)
`define REARM_HOLD_S 4'hA
`define ALARM_HOLD_S 5'h1E

// current thresholds, percent of rating
`define PCT_SCALE 24'h000064
`define START_PCT 24'h000002
`define IDLE_PCT 24'h000001

// current status codes
`define CUR_IDLE 2'h0
`define CUR_CHARGING 2'h1
`define CUR_DISCHARGING 2'h2

// log geometry
`define LOG_DEPTH 8'h84
`define LOG_LAST 8'h83
`define ALARM_LEVEL 8'h80
`define REC_W 118

// limits
`define DUR_MAX 17'h1869F
`define BKT0_MAX 17'h0001E
`define BKT1_MAX 17'h0005A
`define BKT2_MAX 17'h000F0
`define TEMP_MAX 8'h7E
`define VALUE_MAX 16'hFFFF

// energy and charge conversions
`define WS_PER_TENTH_KWH 19'h57E40
`define TENTH_AS_PER_AH 17'h08CA0

// reset values
`define MONITOR_EN_RESET 1'b1
`define SEQ_FIRST 16'h0001

`endif

//--- verilog/pulse_divider.v
`timescale 1ns/1ps
module pulse_divider #(
  parameter [31:0] DIVIDE = 32'h00000010
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire restart_i,
  output reg tick_o
);
  reg [31:0] count;

  // restart lines the second boundary up with the cycle start
  always @(posedge clk_i) begin
    if (!rst_b_i || restart_i) begin
      count <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (count == DIVIDE - 32'h00000001) begin
      count <= 32'h00000000;
      tick_o <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick_o <= 1'b0;
    end
  end
endmodule

//--- verilog/wide_accumulator.v
`timescale 1ns/1ps
module wide_accumulator (
  input wire clk_i,
  input wire rst_b_i,
  input wire clear_i,
  input wire add_i,
  input wire [31:0] addend_i,
  output reg [63:0] total_o
);
  // a clear in the same cycle as an add zeroes the total before the add
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      total_o <= 64'h0000000000000000;
    end else if (add_i) begin
      total_o <= (clear_i ? 64'h0000000000000000 : total_o) + {32'h00000000, addend_i};
    end else if (clear_i) begin
      total_o <= 64'h0000000000000000;
    end
  end
endmodule

//--- verilog/discharge_cycle_monitor.v
`timescale 1ns/1ps
`include "cycle_log_defs.vh"
// Operation
// - start on discharge above 2% when armed
// - end and re-arm within +/-1%
// - expose charging, discharging or idle status
// - current in tenths of an ampere
// - end-of-discharge fault commits and re-arms
// - link loss commits, re-arm after 10 s
// - capture timestamp and temperature at start
// - track min voltage, peak current, energy
// - store duration; update summary totals at end
// - 132-entry circular log, oldest overwritten
// - near-full alarm above 128, 30 s min
// - duration saturates at 99999 seconds
// - buckets 0-30, 31-90, 91-240 seconds
// - rising sequence id, newest read first
// - energy and peak current saturate unsigned
// - temperature valid only 0 to 126
// - summary totals in 64-bit accumulators
// - authorized clears of log and summary
// - monitoring enabled after reset
module discharge_cycle_monitor #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
  input wire MCLK_I,
  input wire RST_B_I,
  input wire signed [15:0] BAT_CURRENT_I,
  input wire [15:0] DISCHARGE_RATING_I,
  input wire [9:0] DC_BUS_VOLT_I,
  input wire [15:0] BAT_POWER_I,
  input wire signed [7:0] BAT_TEMP_I,
  input wire [31:0] TIME_STAMP_I,
  input wire EOD_FAULT_I,
  input wire CONTROLLER_LINK_FAIL_I,
  input wire MONITOR_CFG_WR_I,
  input wire MONITOR_CFG_EN_I,
  input wire PASSWORD_OK_I,
  input wire CLEAR_CYCLE_LOG_I,
  input wire CLEAR_SUMMARY_I,
  input wire [7:0] RD_AGE_I,
  output wire [1:0] CURRENT_STATE_O,
  output wire MONITOR_EN_O,
  output wire CYCLE_ACTIVE_O,
  output wire REARM_WAIT_O,
  output reg COMMIT_O,
  output wire LOG_NEAR_FULL_O,
  output wire [7:0] LOG_COUNT_O,
  output reg RD_VALID_O,
  output wire [15:0] RD_SEQ_O,
  output wire [31:0] RD_STAMP_O,
  output wire [7:0] RD_TEMP_O,
  output wire RD_TEMP_VALID_O,
  output wire [9:0] RD_MIN_VOLT_O,
  output wire [15:0] RD_PEAK_CUR_O,
  output wire [15:0] RD_KWH_O,
  output wire [16:0] RD_DURATION_O,
  output wire [1:0] RD_BUCKET_O,
  output wire [63:0] SUM_CYCLES_O,
  output wire [63:0] SUM_SECONDS_O,
  output wire [63:0] SUM_AMP_HOURS_O,
  output wire [63:0] SUM_KWH_O
);
  localparam [1:0] ST_ARMED = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;

  reg [1:0] state;
  reg [1:0] cur_state;
  reg monitor_en;
  reg [31:0] rec_stamp;
  reg [7:0] rec_temp;
  reg rec_temp_ok;
  reg [9:0] min_volt;
  reg [15:0] peak_cur;
  reg [15:0] kwh;
  reg [16:0] dur;
  reg [18:0] ws_frac;
  reg [16:0] as_frac;
  reg [15:0] cycle_ah;
  reg [15:0] seq;
  reg [3:0] hold_cnt;
  reg [4:0] alarm_cnt;
  reg [7:0] wr_ptr;
  reg [7:0] count;
  reg [`REC_W-1:0] log_mem [0:`LOG_DEPTH-1];
  reg [`REC_W-1:0] rd_data;
  reg [1:0] bucket;
  reg [7:0] rd_slot;
  wire tick;
  wire negative;
  wire [16:0] mag;
  wire [15:0] mag_sat;
  wire [23:0] mag_pct;
  wire [23:0] rating_ext;
  wire above_start;
  wire within_idle;
  wire start_now;
  wire end_now;
  wire commit;
  wire clr_log;
  wire clr_sum;
  wire [18:0] ws_sum;
  wire [16:0] as_sum;

  assign negative = BAT_CURRENT_I[15];
  // magnitude is one bit wider so -32768 does not wrap
  assign mag = negative ? (17'h00000 - {BAT_CURRENT_I[15], BAT_CURRENT_I}) :
               {1'b0, BAT_CURRENT_I};
  assign mag_sat = mag[16] ? `VALUE_MAX : mag[15:0];
  assign mag_pct = {7'h00, mag} * `PCT_SCALE;
  assign rating_ext = {8'h00, DISCHARGE_RATING_I};
  assign above_start = mag_pct > (rating_ext * `START_PCT);
  assign within_idle = mag_pct <= (rating_ext * `IDLE_PCT);

  // three-way status from the 1% band
  always @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      cur_state <= `CUR_IDLE;
    end else if (within_idle) begin
      cur_state <= `CUR_IDLE;
    end else if (negative) begin
      cur_state <= `CUR_DISCHARGING;
    end else begin
      cur_state <= `CUR_CHARGING;
    end
  end

  always @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      monitor_en <= `MONITOR_EN_RESET;
    end else if (MONITOR_CFG_WR_I) begin
      monitor_en <= MONITOR_CFG_EN_I;
    end
  end

  assign start_now = (state == ST_ARMED) && monitor_en && negative && above_start &&
                     !CONTROLLER_LINK_FAIL_I;
  assign end_now = within_idle || EOD_FAULT_I || CONTROLLER_LINK_FAIL_I;
  assign commit = (state == ST_RUN) && end_now;
  assign clr_log = CLEAR_CYCLE_LOG_I && PASSWORD_OK_I;
  assign clr_sum = CLEAR_SUMMARY_I && PASSWORD_OK_I;

  pulse_divider #(
    .DIVIDE(TICK_CYCLES)
  ) second_tick (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .restart_i(start_now),
    .tick_o(tick)
  );

  always @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      state <= ST_ARMED;
      hold_cnt <= 4'h0;
    end else begin
      case (state)
        ST_ARMED: begin
          if (CONTROLLER_LINK_FAIL_I) begin
            state <= ST_HOLD;
            hold_cnt <= 4'h0;
          end else if (start_now) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (CONTROLLER_LINK_FAIL_I) begin
            state <= ST_HOLD;
            hold_cnt <= 4'h0;
          end else if (end_now) begin
            state <= ST_ARMED;
          end
        end
        ST_HOLD: begin
          // counted from the loss itself, not from the link coming back
          if (tick) begin
            if (hold_cnt == `REARM_HOLD_S - 4'h1) begin
              state <= ST_ARMED;
            end else begin
              hold_cnt <= hold_cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_ARMED;
        end
      endcase
    end
  end

  assign ws_sum = ws_frac + {3'h0, BAT_POWER_I};
  assign as_sum = as_frac + mag;

  // per-cycle capture and tracking
  always @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      rec_stamp <= 32'h00000000;
      rec_temp <= 8'h00;
      rec_temp_ok <= 1'b0;
      min_volt <= 10'h000;
      peak_cur <= 16'h0000;
      kwh <= 16'h0000;
      dur <= 17'h00000;
      ws_frac <= 19'h00000;
      as_frac <= 17'h00000;
      cycle_ah <= 16'h0000;
    end else if (start_now) begin
      rec_stamp <= TIME_STAMP_I;
      rec_temp <= BAT_TEMP_I;
      rec_temp_ok <= !BAT_TEMP_I[7] && (BAT_TEMP_I <= $signed(`TEMP_MAX));
      min_volt <= DC_BUS_VOLT_I;
      peak_cur <= mag_sat;
      kwh <= 16'h0000;
      dur <= 17'h00000;
      ws_frac <= 19'h00000;
      as_frac <= 17'h00000;
      cycle_ah <= 16'h0000;
    end else if (state == ST_RUN) begin
      if (DC_BUS_VOLT_I < min_volt) begin
        min_volt <= DC_BUS_VOLT_I;
      end
      if (negative && (mag_sat > peak_cur)) begin
        peak_cur <= mag_sat;
      end
      if (tick) begin
        if (dur != `DUR_MAX) begin
          dur <= dur + 17'h00001;
        end
        // one step per second is enough: power stays below one tenth kWh-second
        if (ws_sum >= `WS_PER_TENTH_KWH) begin
          ws_frac <= ws_sum - `WS_PER_TENTH_KWH;
          if (kwh != `VALUE_MAX) begin
            kwh <= kwh + 16'h0001;
          end
        end else begin
          ws_frac <= ws_sum;
        end
        if (as_sum >= `TENTH_AS_PER_AH) begin
          as_frac <= as_sum - `TENTH_AS_PER_AH;
          if (cycle_ah != `VALUE_MAX) begin
            cycle_ah <= cycle_ah + 16'h0001;
          end
        end else begin
          as_frac <= as_sum;
        end
      end
    end
  end

  always @* begin
    if (dur <= `BKT0_MAX) begin
      bucket = 2'h0;
    end else if (dur <= `BKT1_MAX) begin
      bucket = 2'h1;
    end else if (dur <= `BKT2_MAX) begin
      bucket = 2'h2;
    end else begin
      bucket = 2'h3;
    end
  end

  // log write; a commit in the same cycle as a clear survives the clear
  always @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      wr_ptr <= 8'h00;
      count <= 8'h00;
      seq <= `SEQ_FIRST;
      COMMIT_O <= 1'b0;
    end else begin
      COMMIT_O <= commit;
      if (commit) begin
        seq <= seq + 16'h0001;
        if (clr_log) begin
          wr_ptr <= 8'h01;
          count <= 8'h01;
        end else begin
          wr_ptr <= (wr_ptr == `LOG_LAST) ? 8'h00 : wr_ptr + 8'h01;
          if (count != `LOG_DEPTH) begin
            count <= count + 8'h01;
          end
        end
      end else if (clr_log) begin
        wr_ptr <= 8'h00;
        count <= 8'h00;
      end
    end
  end

  // memory has no reset; stale words are masked by count
  always @(posedge MCLK_I) begin
    if (commit) begin
      log_mem[clr_log ? 8'h00 : wr_ptr] <= {seq, rec_stamp, rec_temp, rec_temp_ok, min_volt,
                                           peak_cur, kwh, dur, bucket};
    end
  end

  // age 0 is the newest record
  always @* begin
    if (wr_ptr > RD_AGE_I) begin
      rd_slot = wr_ptr - 8'h01 - RD_AGE_I;
    end else begin
      rd_slot = wr_ptr + `LOG_LAST - RD_AGE_I;
    end
  end

  always @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      rd_data <= {`REC_W{1'b0}};
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= RD_AGE_I < count;
      if (RD_AGE_I < `LOG_DEPTH) begin
        rd_data <= log_mem[rd_slot];
      end
    end
  end

  assign {RD_SEQ_O, RD_STAMP_O, RD_TEMP_O, RD_TEMP_VALID_O, RD_MIN_VOLT_O, RD_PEAK_CUR_O,
          RD_KWH_O, RD_DURATION_O, RD_BUCKET_O} = rd_data;

  // alarm stays up for the download window even if the log is cleared
  always @(posedge MCLK_I) begin
    if (!RST_B_I) begin
      alarm_cnt <= 5'h00;
    end else if (count > `ALARM_LEVEL) begin
      alarm_cnt <= `ALARM_HOLD_S;
    end else if (tick && (alarm_cnt != 5'h00)) begin
      alarm_cnt <= alarm_cnt - 5'h01;
    end
  end

  // level term covers the cycle before the hold counter loads
  assign LOG_NEAR_FULL_O = (count > `ALARM_LEVEL) || (alarm_cnt != 5'h00);

  wide_accumulator sum_cycles (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .clear_i(clr_sum),
    .add_i(commit),
    .addend_i(32'h00000001),
    .total_o(SUM_CYCLES_O)
  );

  wide_accumulator sum_seconds (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .clear_i(clr_sum),
    .add_i(commit),
    .addend_i({15'h0000, dur}),
    .total_o(SUM_SECONDS_O)
  );

  wide_accumulator sum_amp_hours (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .clear_i(clr_sum),
    .add_i(commit),
    .addend_i({16'h0000, cycle_ah}),
    .total_o(SUM_AMP_HOURS_O)
  );

  wide_accumulator sum_kwh (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .clear_i(clr_sum),
    .add_i(commit),
    .addend_i({16'h0000, kwh}),
    .total_o(SUM_KWH_O)
  );

  assign CURRENT_STATE_O = cur_state;
  assign MONITOR_EN_O = monitor_en;
  assign CYCLE_ACTIVE_O = state == ST_RUN;
  assign REARM_WAIT_O = state == ST_HOLD;
  assign LOG_COUNT_O = count;
endmodule

//--- dv/cycle_log_asserts.sv
`timescale 1ns/1ps
module cycle_log_checker #(
  parameter [31:0] TICK_CYCLES = 32'h10
) (
  input wire MCLK_I,
  input wire RST_B_I,
  input wire signed [15:0] BAT_CURRENT_I,
  input wire [15:0] DISCHARGE_RATING_I,
  input wire EOD_FAULT_I,
  input wire CONTROLLER_LINK_FAIL_I,
  input wire [1:0] CURRENT_STATE_O,
  input wire MONITOR_EN_O,
  input wire CYCLE_ACTIVE_O,
  input wire REARM_WAIT_O,
  input wire COMMIT_O,
  input wire LOG_NEAR_FULL_O,
  input wire [7:0] LOG_COUNT_O,
  input wire RD_VALID_O,
  input wire [7:0] RD_TEMP_O,
  input wire RD_TEMP_VALID_O,
  input wire [16:0] RD_DURATION_O,
  input wire [1:0] RD_BUCKET_O
);
  wire [31:0] ext = {{16{BAT_CURRENT_I[15]}}, BAT_CURRENT_I};
  wire [31:0] mag = BAT_CURRENT_I[15] ? 32'h0 - ext : ext;
  wire [31:0] pct = {16'h0, DISCHARGE_RATING_I};
  wire quiet = mag * 32'h64 <= pct;
  wire big_dis = BAT_CURRENT_I[15] && mag * 32'h64 > pct * 32'h2;
  wire [1:0] st = quiet ? 2'h0 : (BAT_CURRENT_I[15] ? 2'h2 : 2'h1);
  wire [1:0] bkt = RD_DURATION_O <= 17'h1E ? 2'h0 : RD_DURATION_O <= 17'h5A ? 2'h1 :
    RD_DURATION_O <= 17'hF0 ? 2'h2 : 2'h3;
  reg [31:0] held;
  // hold length counted here, too long for a repetition
  always @(posedge MCLK_I) begin
    if (!RST_B_I || !REARM_WAIT_O)
      held <= 32'h0;
    else
      held <= held + 32'h1;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  a_start_cycle: assert property (!CYCLE_ACTIVE_O && !REARM_WAIT_O && MONITOR_EN_O &&
    big_dis && !CONTROLLER_LINK_FAIL_I |=> CYCLE_ACTIVE_O) else $error("no start");
  a_quiet_end: assert property (CYCLE_ACTIVE_O && quiet |=> !CYCLE_ACTIVE_O)
    else $error("no end");
  a_state_code: assert property (1'b1 |=> CURRENT_STATE_O == $past(st))
    else $error("bad status");
  a_fault_commit: assert property (CYCLE_ACTIVE_O && EOD_FAULT_I |=>
    !CYCLE_ACTIVE_O && COMMIT_O) else $error("fault not saved");
  a_link_close: assert property (CYCLE_ACTIVE_O && CONTROLLER_LINK_FAIL_I |=>
    REARM_WAIT_O && COMMIT_O) else $error("link loss not saved");
  a_hold_len: assert property ($fell(REARM_WAIT_O) |-> held >= 9 * TICK_CYCLES &&
    held <= 10 * TICK_CYCLES + 2) else $error("hold length");
  a_alarm_level: assert property (LOG_COUNT_O > 8'h80 |-> LOG_NEAR_FULL_O)
    else $error("no alarm");
  a_count_step: assert property ($fell(CYCLE_ACTIVE_O) |-> LOG_COUNT_O ==
    ($past(LOG_COUNT_O) == 8'h84 ? 8'h84 : $past(LOG_COUNT_O) + 8'h1)) else $error("count");
  a_temp_range: assert property (RD_VALID_O |-> RD_TEMP_VALID_O == (RD_TEMP_O <= 8'h7E))
    else $error("temp flag");
  a_bucket_sort: assert property (RD_VALID_O |-> RD_BUCKET_O == bkt &&
    RD_DURATION_O <= 17'h1869F) else $error("bucket");
  a_enable_reset: assert property ($rose(RST_B_I) |-> MONITOR_EN_O)
    else $error("monitor off");
  c_alarm: cover property ($rose(LOG_NEAR_FULL_O));
  c_hold_done: cover property ($fell(REARM_WAIT_O));
  c_commit: cover property (COMMIT_O);
endmodule
bind discharge_cycle_monitor cycle_log_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.*);

//--- dv/ups_main_controller.sv
`timescale 1ns/1ps
module ups_main_controller (
  input wire clk_i,
  input wire signed [15:0] cur_cmd_i,
  input wire signed [7:0] temp_cmd_i,
  input wire eod_cmd_i,
  input wire link_cmd_i,
  output wire signed [15:0] cur_o,
  output reg [9:0] volt_o,
  output wire [15:0] power_o,
  output wire signed [7:0] temp_o,
  output reg [31:0] stamp_o,
  output wire eod_o,
  output wire link_o
);
  assign cur_o = cur_cmd_i;
  assign power_o = cur_cmd_i[15] ? 16'h1388 : 16'h0;
  assign temp_o = temp_cmd_i;
  assign eod_o = eod_cmd_i;
  assign link_o = link_cmd_i;
  initial begin
    volt_o = 10'h21C;
    stamp_o = 32'h0;
  end
  // bus wanders under load so the minimum tracker sees motion
  always @(posedge clk_i) begin
    stamp_o <= #1 stamp_o + 32'h1;
    volt_o <= #1 cur_cmd_i[15] ? 10'h1F4 - {7'h0, stamp_o[2:0]} : 10'h21C;
  end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam [31:0] TK = 32'h10;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg signed [15:0] cur = 16'sh0;
  reg signed [7:0] tmp = 8'sh19;
  reg eod = 1'b0, lnk = 1'b0, wr = 1'b0, en = 1'b1, pw = 1'b0, clg = 1'b0, csm = 1'b0;
  reg [7:0] age = 8'h0;
  integer seed = 32'h83D9;
  integer compares = 0, miscompares = 0, i, d, seq = 0, nrec = 0, nsum = 0;
  integer m, st, dd, nsec = 0, nkw = 0, nah = 0;
  wire signed [15:0] bc;
  wire signed [7:0] bt;
  wire [9:0] bv, mv;
  wire [15:0] bp, rs, pk, kw;
  wire [31:0] ts, rsp;
  wire ef, lf, act, rw, nf, rv, tv, men;
  wire [1:0] cs, bk;
  wire [7:0] cnt, rt;
  wire [16:0] rd;
  wire [63:0] sc, ss, sa, sk;
  always #25 clk = ~clk;
  ups_main_controller far (.clk_i(clk), .cur_cmd_i(cur), .temp_cmd_i(tmp), .eod_cmd_i(eod),
    .link_cmd_i(lnk), .cur_o(bc), .volt_o(bv), .power_o(bp), .temp_o(bt), .stamp_o(ts),
    .eod_o(ef), .link_o(lf));
  discharge_cycle_monitor #(.TICK_CYCLES(TK)) uut (.MCLK_I(clk), .RST_B_I(rst_b),
    .BAT_CURRENT_I(bc), .DISCHARGE_RATING_I(16'h03E8), .DC_BUS_VOLT_I(bv),
    .BAT_POWER_I(bp), .BAT_TEMP_I(bt), .TIME_STAMP_I(ts), .EOD_FAULT_I(ef),
    .CONTROLLER_LINK_FAIL_I(lf), .MONITOR_CFG_WR_I(wr), .MONITOR_CFG_EN_I(en),
    .PASSWORD_OK_I(pw), .CLEAR_CYCLE_LOG_I(clg), .CLEAR_SUMMARY_I(csm), .RD_AGE_I(age),
    .CURRENT_STATE_O(cs), .MONITOR_EN_O(men), .CYCLE_ACTIVE_O(act), .REARM_WAIT_O(rw),
    .COMMIT_O(), .LOG_NEAR_FULL_O(nf), .LOG_COUNT_O(cnt), .RD_VALID_O(rv), .RD_SEQ_O(rs),
    .RD_STAMP_O(rsp), .RD_TEMP_O(rt), .RD_TEMP_VALID_O(tv), .RD_MIN_VOLT_O(mv),
    .RD_PEAK_CUR_O(pk), .RD_KWH_O(kw), .RD_DURATION_O(rd), .RD_BUCKET_O(bk),
    .SUM_CYCLES_O(sc), .SUM_SECONDS_O(ss), .SUM_AMP_HOURS_O(sa), .SUM_KWH_O(sk));
  function [1:0] est(input signed [15:0] c);
    integer m;
    begin
      m = c < 0 ? -c : c;
      est = m * 32'h64 <= 32'h3E8 ? 2'h0 : c < 0 ? 2'h2 : 2'h1;
    end
  endfunction
  function [1:0] ebk(input integer t);
    ebk = t <= 32'h1E ? 2'h0 : t <= 32'h5A ? 2'h1 : t <= 32'hF0 ? 2'h2 : 2'h3;
  endfunction
  task final_report;
    begin
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [63:0] e, input [63:0] g);
    begin
      compares = compares + 1;
      if (e !== g) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wact(input v);
    integer k;
    begin
      k = 0;
      while (act !== v && k < 8) begin
        cyc(1);
        k = k + 1;
      end
      chk(v, act);
      if (act !== v) final_report;
    end
  endtask
  task run(input signed [15:0] c, input integer len, input integer how);
    begin
      cur = c;
      wact(1'b1);
      // stamp advances once per edge from zero; start edge is one ns back
      st = ($time - 32'h1A) / 32'h32;
      cyc(len);
      eod = how == 1;
      lnk = how == 2;
      if (how == 0) cur = 16'sh0;
      wact(1'b0);
      cur = 16'sh0;
      eod = 1'b0;
      lnk = 1'b0;
      seq = seq + 1;
      nrec = nrec < 32'h84 ? nrec + 1 : 32'h84;
      nsum = nsum + 1;
      cyc(3);
      m = -c;
      // divider restarts at the start edge, so whole seconds before the end edge
      dd = (len - 1) / TK;
      nsec = nsec + dd;
      nkw = nkw + dd * 32'h1388 / 32'h57E40;
      nah = nah + dd * m / 32'h8CA0;
      chk(nrec, cnt);
      chk(nsum, sc);
      chk(seq, rs);
      chk(dd, rd);
      chk(m, pk);
      chk(dd * 32'h1388 / 32'h57E40, kw);
      chk(st, rsp);
      chk(nsec, ss);
      chk(nkw, sk);
      chk(nah, sa);
    end
  endtask
  // clear strobes one cycle; password dropped with it
  task clr(input p, input w);
    begin
      pw = p;
      clg = !w;
      csm = w;
      cyc(1);
      clg = 1'b0;
      csm = 1'b0;
      pw = 1'b0;
      cyc(1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    cyc(2);
    chk(1, men);
    chk(0, cnt);
    for (i = 0; i < 12; i = i + 1) begin
      cur = i < 2 ? 16'shB - i : i < 4 ? -16'sh8 - i : i == 4 ? -16'sh14 : $random(seed) % 21;
      cyc(2);
      chk(est(cur), cs);
      chk(0, act);
    end
    $display("test status done");
    for (i = 0; i < 4; i = i + 1) begin
      d = i == 0 ? 5 : i == 1 ? 40 : i == 2 ? 100 : 250;
      tmp = i == 0 ? 8'sh7E : i == 1 ? 8'sh7F : $random(seed);
      run(-16'sh15 - i, d * TK, 0);
      chk(ebk(d), bk);
      chk(1, rd + 1 >= d && rd <= d + 1);
      chk({tmp}, rt);
      chk(!tmp[7] && tmp != 8'sh7F, tv);
      chk(10'h1ED, mv);
    end
    $display("test duration done");
    run(-16'sh64, 4, 1);
    run(-16'sh64, 4, 2);
    chk(1, rw);
    cur = -16'sh64;
    cyc(20);
    chk(0, act);
    cur = 16'sh0;
    i = 0;
    while (rw !== 1'b0 && i < 12 * TK) begin
      cyc(1);
      i = i + 1;
    end
    chk(0, rw);
    if (rw !== 1'b0) final_report;
    $display("test fault done");
    en = 1'b0;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
    chk(0, men);
    cur = -16'sh64;
    cyc(5);
    chk(0, act);
    cur = 16'sh0;
    en = 1'b1;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
    $display("test enable done");
    for (i = 0; i < 130; i = i + 1)
      run(-16'sh15 - ($random(seed) & 16'h1FF), 2, i % 3 == 0);
    chk(1, nf);
    age = 8'h83;
    cyc(2);
    chk(1, rv);
    chk(seq - 131, rs);
    age = 8'h84;
    cyc(2);
    chk(0, rv);
    age = 8'h0;
    $display("test wrap done");
    clr(1'b0, 1'b0);
    chk(nrec, cnt);
    clr(1'b1, 1'b0);
    nrec = 0;
    chk(0, cnt);
    cyc(28 * TK);
    chk(1, nf);
    cyc(4 * TK);
    chk(0, nf);
    clr(1'b1, 1'b1);
    nsum = 0;
    nsec = 0;
    nkw = 0;
    nah = 0;
    chk(0, sc);
    run(-16'sh32, 3, 0);
    $display("test clear done");
    final_report;
  end
endmodule
